// [hw/bbx_pkg.sv]
/*
  Shared types and constants of the bit, skip, branch and call
  execution block. Assumes a 15-bit program counter, a 7-bit file
  address and 8-bit file registers.
*/
package bbx_pkg;

  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int BBX_PC_W = 15;
  localparam int BBX_FADDR_W = 7;
  localparam int BBX_DATA_W = 8;
  localparam int BBX_BSEL_W = 3;
  localparam int BBX_OFFS_W = 9;
  localparam int BBX_TARGET_W = 11;
  localparam int BBX_LATCH_HI = 6;  // Latch bits feeding PC[14:11]
  localparam int BBX_LATCH_LO = 3;

  // ----------------------------------------------------------------
  // Reset values and increments
  // ----------------------------------------------------------------
  localparam logic [BBX_PC_W-1:0] BBX_PC_RST = 15'h0000;
  localparam logic [BBX_PC_W-1:0] BBX_PC_STEP = 15'h0001;
  localparam logic [BBX_DATA_W-1:0] BBX_DATA_RST = 8'h00;
  localparam logic [BBX_FADDR_W-1:0] BBX_FADDR_RST = 7'h00;

  // ----------------------------------------------------------------
  // Operations of this group
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BIT_CLEAR_OP = 3'h0,
    BIT_SET_OP = 3'h1,
    SKIP_IF_BIT_CLEAR_OP = 3'h2,
    SKIP_IF_BIT_SET_OP = 3'h3,
    RELATIVE_BRANCH_OP = 3'h4,
    ACCUMULATOR_BRANCH_OP = 3'h5,
    SUBROUTINE_CALL_OP = 3'h6,
    NO_OPERATION = 3'h7
  } bbx_op_e;

  // Decoded instruction handed over by fetch/decode
  typedef struct packed {
    bbx_op_e op;
    logic [BBX_FADDR_W-1:0] faddr;
    logic [BBX_BSEL_W-1:0] bsel;
    logic [BBX_OFFS_W-1:0] offs;
    logic [BBX_TARGET_W-1:0] target;
  } bbx_instr_s;

  // One-hot execution states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_EXEC = 3'h2,
    ST_SECOND = 3'h4
  } bbx_state_e;

endpackage

// [hw/bbx_bitop.sv]
/*
  Combinational bit unit: picks one bit of a file register, and forms
  the register with that bit forced to the requested value.
  Assumes the data arrive from logic on the same clock.
*/
`timescale 1ns/1ps
module bbx_bitop #(
  parameter int DATA_W = 8,
  parameter int BSEL_W = 3
) (
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [BSEL_W-1:0] bsel,
  input wire logic set_val,
  output logic bit_val,
  output logic [DATA_W-1:0] data_out
);

  // ----------------------------------------------------------------
  // Per-bit select and replace
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] hit;

  // Only the selected lane changes, others pass untouched
  for (genvar i = 0; i < DATA_W; i++) begin : g_lane
    assign hit[i] = (bsel == BSEL_W'(i));
    assign data_out[i] = hit[i] ? set_val : data_in[i];
  end

  assign bit_val = |(hit & data_in);

endmodule

// [hw/bbx_exec.sv]
/*
  Execution stage for bit clear/set, bit test and skip, relative
  branches and the absolute subroutine call.
  Assumes fetch/decode, the file memory, the program counter and the
  return stack all run on CLOCK; FILE_RDATA answers FILE_RADDR in the
  same cycle without a register.
*/
// Function
// (RULE1) Bit clear writes zero to bit 0..7 of file register 0..127.
// (RULE2) Bit set writes one to selected bit, other bits unchanged.
// (RULE3) Relative branch loads PC+1 plus signed 9-bit offset; two cycles.
// (RULE4) Accumulator branch loads PC+1 plus unsigned accumulator; two cycles.
// (RULE5) Skip-if-clear with bit zero discards next instruction; two cycles.
// (RULE6) Skip-if-clear with bit one lets next instruction run.
// (RULE7) Skip-if-set skips on one, two cycles; runs next on zero.
// (RULE8) Call pushes PC+1 on the return stack before loading PC.
// (RULE9) Call loads 11-bit target into PC[10:0].
// (RULE10) Call fills PC[14:11] from latch bits [6:3].
// (RULE11) Call completes in two instruction cycles.
// (RULE12) No operation here changes carry, digit-carry or zero flags.
`timescale 1ns/1ps
module bbx_exec (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire bbx_pkg::bbx_instr_s IN_INSTR,
  input wire logic [bbx_pkg::BBX_PC_W-1:0] IN_PC,
  input wire logic [bbx_pkg::BBX_DATA_W-1:0] ACCUM,
  input wire logic [bbx_pkg::BBX_DATA_W-1:0] PC_HIGH_LATCH,
  output logic [bbx_pkg::BBX_FADDR_W-1:0] FILE_RADDR,
  input wire logic [bbx_pkg::BBX_DATA_W-1:0] FILE_RDATA,
  output logic FILE_WE,
  output logic [bbx_pkg::BBX_FADDR_W-1:0] FILE_WADDR,
  output logic [bbx_pkg::BBX_DATA_W-1:0] FILE_WDATA,
  output logic PC_LOAD,
  output logic [bbx_pkg::BBX_PC_W-1:0] PC_NEW,
  output logic STACK_PUSH,
  output logic [bbx_pkg::BBX_PC_W-1:0] TOP_OF_RETURN_STACK,
  output logic SKIP_NEXT,
  output logic FLAG_WE,
  output logic OP_DONE,
  output logic OP_TWO_CYCLE
);
  import bbx_pkg::*;

  // ----------------------------------------------------------------
  // State and latched instruction
  // ----------------------------------------------------------------
  bbx_state_e state_r;
  bbx_state_e state_nxt;
  bbx_instr_s instr_r;
  logic [BBX_PC_W-1:0] pc_r;
  logic [BBX_PC_W-1:0] pc_inc;
  logic [BBX_PC_W-1:0] offs_ext;
  logic [BBX_PC_W-1:0] accum_ext;
  logic take;
  logic bit_val;
  logic [BBX_DATA_W-1:0] bit_result;
  logic set_val;
  logic skip_now;
  logic two_cyc;

  logic [BBX_FADDR_W-1:0] raddr_r;
  logic we_r;
  logic [BBX_FADDR_W-1:0] waddr_r;
  logic [BBX_DATA_W-1:0] wdata_r;
  logic pc_load_r;
  logic [BBX_PC_W-1:0] pc_new_r;
  logic push_r;
  logic [BBX_PC_W-1:0] tos_r;
  logic skip_r;
  logic flag_we_r;
  logic done_r;
  logic two_r;

  // New instructions only while idle; one op in flight at a time
  assign IN_READY = (state_r == ST_IDLE);
  assign take = IN_VALID && IN_READY;

  // ----------------------------------------------------------------
  // Address arithmetic
  // ----------------------------------------------------------------
  // Fetch has already moved on, so every relative target starts at PC+1
  assign pc_inc = pc_r + BBX_PC_STEP;
  assign offs_ext = {{(BBX_PC_W-BBX_OFFS_W){instr_r.offs[BBX_OFFS_W-1]}},
                     instr_r.offs};
  assign accum_ext = {{(BBX_PC_W-BBX_DATA_W){1'b0}}, ACCUM};

  // Set lane value: one only for the bit-set operation
  assign set_val = (instr_r.op == BIT_SET_OP);

  bbx_bitop #(
    .DATA_W(BBX_DATA_W),
    .BSEL_W(BBX_BSEL_W)
  ) u_bitop (
    .data_in(FILE_RDATA),
    .bsel(instr_r.bsel),
    .set_val(set_val),
    .bit_val(bit_val),
    .data_out(bit_result)
  );

  // Skip decision for the two test operations
  always_comb begin
    skip_now = 1'b0;
    if (instr_r.op == SKIP_IF_BIT_CLEAR_OP) begin
      skip_now = !bit_val; // RULE5 RULE6
    end else if (instr_r.op == SKIP_IF_BIT_SET_OP) begin
      skip_now = bit_val; // RULE7
    end
  end

  // Ops that need a second cycle from the execute state
  always_comb begin
    case (instr_r.op)
      RELATIVE_BRANCH_OP: two_cyc = 1'b1;
      ACCUMULATOR_BRANCH_OP: two_cyc = 1'b1;
      SUBROUTINE_CALL_OP: two_cyc = 1'b1;
      default: two_cyc = skip_now;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Execute, then an extra state for branches, calls and skips
  always_comb begin
    case (state_r)
      ST_IDLE: state_nxt = take ? ST_EXEC : ST_IDLE;
      ST_EXEC: state_nxt = two_cyc ? ST_SECOND : ST_IDLE;
      ST_SECOND: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Capture the instruction and its own address on acceptance
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      instr_r <= '0;
      pc_r <= BBX_PC_RST;
      raddr_r <= BBX_FADDR_RST;
    end else if (take) begin
      instr_r <= IN_INSTR;
      pc_r <= IN_PC;
      raddr_r <= IN_INSTR.faddr;
    end
  end

  // ----------------------------------------------------------------
  // File write-back
  // ----------------------------------------------------------------
  // Read-modify-write of the whole byte; only the chosen bit moves
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      we_r <= 1'b0;
      waddr_r <= BBX_FADDR_RST;
      wdata_r <= BBX_DATA_RST;
    end else begin
      we_r <= 1'b0;
      if (state_r == ST_EXEC &&
          (instr_r.op == BIT_CLEAR_OP || instr_r.op == BIT_SET_OP)) begin
        we_r <= 1'b1; // RULE1 RULE2
        waddr_r <= instr_r.faddr;
        wdata_r <= bit_result; // RULE1 RULE2
      end
    end
  end

  // ----------------------------------------------------------------
  // Program counter and return stack
  // ----------------------------------------------------------------
  // Call pushes in execute, loads PC one cycle later
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pc_load_r <= 1'b0;
      pc_new_r <= BBX_PC_RST;
      push_r <= 1'b0;
      tos_r <= BBX_PC_RST;
    end else begin
      pc_load_r <= 1'b0;
      push_r <= 1'b0;
      if (state_r == ST_EXEC) begin
        case (instr_r.op)
          RELATIVE_BRANCH_OP: begin
            pc_load_r <= 1'b1;
            pc_new_r <= pc_inc + offs_ext; // RULE3
          end
          ACCUMULATOR_BRANCH_OP: begin
            pc_load_r <= 1'b1;
            pc_new_r <= pc_inc + accum_ext; // RULE4
          end
          SUBROUTINE_CALL_OP: begin
            push_r <= 1'b1; // RULE8
            tos_r <= pc_inc; // RULE8
          end
          default: begin
            pc_load_r <= 1'b0;
          end
        endcase
      end else if (state_r == ST_SECOND &&
                   instr_r.op == SUBROUTINE_CALL_OP) begin
        pc_load_r <= 1'b1;
        pc_new_r <= {PC_HIGH_LATCH[BBX_LATCH_HI:BBX_LATCH_LO], // RULE10
                     instr_r.target}; // RULE9
      end
    end
  end

  // ----------------------------------------------------------------
  // Skip, completion and status flags
  // ----------------------------------------------------------------
  // Skip tells fetch to replace the next instruction by a no-operation
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      skip_r <= 1'b0;
      done_r <= 1'b0;
      two_r <= 1'b0;
    end else begin
      skip_r <= (state_r == ST_EXEC) && skip_now; // RULE5 RULE7
      done_r <= (state_r == ST_EXEC && !two_cyc) || (state_r == ST_SECOND);
      two_r <= (state_r == ST_SECOND); // RULE3 RULE4 RULE11
    end
  end

  // Status flags are never written by this group
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      flag_we_r <= 1'b0;
    end else begin
      flag_we_r <= 1'b0; // RULE12
    end
  end

  assign FILE_RADDR = raddr_r;
  assign FILE_WE = we_r;
  assign FILE_WADDR = waddr_r;
  assign FILE_WDATA = wdata_r;
  assign PC_LOAD = pc_load_r;
  assign PC_NEW = pc_new_r;
  assign STACK_PUSH = push_r;
  assign TOP_OF_RETURN_STACK = tos_r;
  assign SKIP_NEXT = skip_r;
  assign FLAG_WE = flag_we_r;
  assign OP_DONE = done_r;
  assign OP_TWO_CYCLE = two_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  // Cleared bit is zero, rest equal the byte read
  property p_clear_bit;
    (state_r == ST_EXEC && instr_r.op == BIT_CLEAR_OP) |=>
      FILE_WE && !FILE_WDATA[instr_r.bsel] &&
      FILE_WDATA == ($past(FILE_RDATA) & ~(8'h01 << instr_r.bsel)) &&
      FILE_WADDR == $past(FILE_RADDR);
  endproperty
  a_clear_bit: assert property (p_clear_bit) // RULE1
    else $error("bit clear did not write zero");

  property p_set_bit;
    (state_r == ST_EXEC && instr_r.op == BIT_SET_OP) |=>
      FILE_WE && FILE_WDATA ==
      ($past(FILE_RDATA) | (8'h01 << instr_r.bsel));
  endproperty
  a_set_bit: assert property (p_set_bit) // RULE2
    else $error("bit set changed wrong bits");

  property p_rel_branch;
    (take && IN_INSTR.op == RELATIVE_BRANCH_OP) |-> ##2
      PC_LOAD && PC_NEW == BBX_PC_W'($past(IN_PC, 2) + 1 +
      {{6{$past(IN_INSTR.offs[8], 2)}}, $past(IN_INSTR.offs, 2)})
      ##1 OP_DONE && OP_TWO_CYCLE;
  endproperty
  a_rel_branch: assert property (p_rel_branch) // RULE3
    else $error("relative branch target or timing wrong");

  property p_acc_branch;
    (take && IN_INSTR.op == ACCUMULATOR_BRANCH_OP) |-> ##2
      PC_LOAD && PC_NEW == BBX_PC_W'($past(IN_PC, 2) + 1 +
      $past(ACCUM, 1)) ##1 OP_DONE && OP_TWO_CYCLE;
  endproperty
  a_acc_branch: assert property (p_acc_branch) // RULE4
    else $error("accumulator branch target or timing wrong");

  property p_skip_clear;
    (state_r == ST_EXEC && instr_r.op == SKIP_IF_BIT_CLEAR_OP &&
     !FILE_RDATA[instr_r.bsel]) |=> SKIP_NEXT ##1 OP_DONE && OP_TWO_CYCLE;
  endproperty
  a_skip_clear: assert property (p_skip_clear) // RULE5
    else $error("skip-if-clear did not skip");

  property p_noskip_clear;
    (state_r == ST_EXEC && instr_r.op == SKIP_IF_BIT_CLEAR_OP &&
     FILE_RDATA[instr_r.bsel]) |=> !SKIP_NEXT && OP_DONE && !OP_TWO_CYCLE;
  endproperty
  a_noskip_clear: assert property (p_noskip_clear) // RULE6
    else $error("skip-if-clear skipped on one");

  property p_skip_set;
    (state_r == ST_EXEC && instr_r.op == SKIP_IF_BIT_SET_OP) |=>
      SKIP_NEXT == $past(FILE_RDATA[instr_r.bsel]) &&
      OP_DONE == !SKIP_NEXT;
  endproperty
  a_skip_set: assert property (p_skip_set) // RULE7
    else $error("skip-if-set decision wrong");

  property p_call_push;
    (take && IN_INSTR.op == SUBROUTINE_CALL_OP) |-> ##2
      STACK_PUSH && !PC_LOAD &&
      TOP_OF_RETURN_STACK == BBX_PC_W'($past(IN_PC, 2) + 1)
      ##1 PC_LOAD && !STACK_PUSH;
  endproperty
  a_call_push: assert property (p_call_push) // RULE8
    else $error("call push not before PC load");

  property p_call_low;
    (take && IN_INSTR.op == SUBROUTINE_CALL_OP) |-> ##3
      PC_NEW[10:0] == $past(IN_INSTR.target, 3);
  endproperty
  a_call_low: assert property (p_call_low) // RULE9
    else $error("call low target wrong");

  property p_call_high;
    (state_r == ST_SECOND && instr_r.op == SUBROUTINE_CALL_OP) |=>
      PC_NEW[14:11] == $past(PC_HIGH_LATCH[6:3]);
  endproperty
  a_call_high: assert property (p_call_high) // RULE10
    else $error("call high bits not from latch");

  property p_call_time;
    (take && IN_INSTR.op == SUBROUTINE_CALL_OP) |-> ##1 !OP_DONE [*2]
      ##1 OP_DONE && OP_TWO_CYCLE && IN_READY;
  endproperty
  a_call_time: assert property (p_call_time) // RULE11
    else $error("call did not take two cycles");

  property p_no_flags;
    !FLAG_WE;
  endproperty
  a_no_flags: assert property (p_no_flags) // RULE12
    else $error("status flags written");

  c_call: cover property (take && IN_INSTR.op == SUBROUTINE_CALL_OP ##3
    PC_LOAD);
  c_skip: cover property (SKIP_NEXT);
  c_write: cover property (FILE_WE);
  c_branch: cover property (PC_LOAD && state_r == ST_SECOND);

endmodule

// [sim/bbx_mem_model.sv]
/*
  Partner model of the data memory file beside the execution stage.
  Assumes the bench preloads cells through the mem array and that all
  traffic runs on the one instruction clock.
*/
`timescale 1ns/1ps
module bbx_mem_model
  import bbx_pkg::*;
(
  input wire logic clock,
  input wire logic [BBX_FADDR_W-1:0] raddr,
  output logic [BBX_DATA_W-1:0] rdata,
  input wire logic we,
  input wire logic [BBX_FADDR_W-1:0] waddr,
  input wire logic [BBX_DATA_W-1:0] wdata
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [BBX_DATA_W-1:0] mem [0:127];

  // Unregistered read, since the stage samples it in the same cycle
  assign rdata = mem[raddr];

  // Write port; takes whatever the stage offers, checks nothing
  always @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
endmodule

// [sim/bbx_exec_tb.sv]
/*
  Self-checking bench for the bit, skip, branch and call stage.
  Assumes the memory model answers reads in the same cycle; drives all
  inputs on the falling edge and samples outputs there too.
*/
`timescale 1ns/1ps
module bbx_exec_tb;
  import bbx_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic in_valid = 1'b0;
  logic in_ready, file_we, pc_load, stack_push, skip_next;
  logic flag_we, op_done, op_two_cycle;
  bbx_instr_s instr = '0;
  logic [14:0] in_pc = '0;
  logic [14:0] pc_new, top_of_return_stack;
  logic [7:0] accum = 8'h00;
  logic [7:0] latch = 8'h00;
  logic [6:0] raddr, waddr;
  logic [7:0] rdata, wdata;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;

  always #50 clock = ~clock;

  bbx_exec i_dut (.CLOCK(clock), .RST_N(rst_n), .IN_VALID(in_valid),
    .IN_READY(in_ready), .IN_INSTR(instr), .IN_PC(in_pc), .ACCUM(accum),
    .PC_HIGH_LATCH(latch), .FILE_RADDR(raddr), .FILE_RDATA(rdata),
    .FILE_WE(file_we), .FILE_WADDR(waddr), .FILE_WDATA(wdata),
    .PC_LOAD(pc_load), .PC_NEW(pc_new), .STACK_PUSH(stack_push),
    .TOP_OF_RETURN_STACK(top_of_return_stack), .SKIP_NEXT(skip_next), .FLAG_WE(flag_we),
    .OP_DONE(op_done), .OP_TWO_CYCLE(op_two_cycle));

  bbx_mem_model i_mem (.clock(clock), .raddr(raddr), .rdata(rdata),
    .we(file_we), .waddr(waddr), .wdata(wdata));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Offer one instruction at a falling edge, then record the pulses
  // {we,load,push,skip,done,two} of cycles 1..3 after the accept.
  // Returning at the cycle-3 falling edge lets the next call go
  // back to back with a two-cycle operation.
  task automatic go(input bbx_op_e o, input logic [6:0] fa,
      input logic [2:0] bs, input logic [8:0] of, input logic [10:0] tg,
      input logic [14:0] pc, input logic [17:0] exp, input logic [17:0] m);
    int k;
    logic [17:0] pat;
    logic fl;
    instr = '{op: o, faddr: fa, bsel: bs, offs: of, target: tg};
    in_pc = pc;
    in_valid = 1'b1;
    k = 0;
    while (in_ready !== 1'b1 && k < 20) begin
      @(negedge clock);
      k++;
    end
    chk(in_ready, 1'b1);
    pat = '0;
    fl = 1'b0;
    for (int c = 0; c < 3; c++) begin
      @(negedge clock);
      if (c == 0) in_valid = 1'b0;
      pat = {pat[11:0], file_we, pc_load, stack_push, skip_next, op_done,
        op_two_cycle};
      fl = fl | flag_we;
    end
    chk(pat & m, exp & m);
    chk(fl, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Every bit position at both ends of the file address range
  task automatic t_bits();
    i_mem.mem[127] = 8'h00;
    i_mem.mem[0] = 8'hFF;
    for (int b = 0; b < 8; b++) begin
      go(BIT_SET_OP, 7'h7F, b[2:0], '0, '0, '0,
        {6'h00, 6'h22, 6'h00}, '1);
      chk(i_mem.mem[127], (9'h002 << b) - 9'h001);
      chk(waddr, 7'h7F);
    end
    for (int b = 0; b < 8; b++) begin
      go(BIT_CLEAR_OP, 7'h00, b[2:0], '0, '0, '0,
        {6'h00, 6'h22, 6'h00}, '1);
      chk(i_mem.mem[0], 8'(8'hFE << b));
    end
    $display("t_bits finished");
  endtask

  // Both tests against a zero and a one bit; the file must not change
  task automatic t_skip();
    logic tk;
    i_mem.mem[5] = 8'hA5;
    for (int s = 0; s < 4; s++) begin
      // Bit 1 of the cell is zero, bit 2 is one
      tk = (s == 0) || (s == 3);
      go(s[1] ? SKIP_IF_BIT_SET_OP : SKIP_IF_BIT_CLEAR_OP, 7'h05,
        s[0] ? 3'h2 : 3'h1, '0, '0, '0,
        tk ? {6'h00, 6'h04, 6'h03} : {6'h00, 6'h02, 6'h00},
        '1);
      chk(i_mem.mem[5], 8'hA5);
    end
    // The substituted no-operation completes in one cycle, no write
    go(NO_OPERATION, 7'h05, '0, '0, '0, '0,
      {6'h00, 6'h02, 6'h00}, '1);
    chk(i_mem.mem[5], 8'hA5);
    $display("t_skip finished");
  endtask

  // Offset extremes, wrap of the counter, accumulator as unsigned
  task automatic t_branch();
    go(RELATIVE_BRANCH_OP, '0, '0, 9'h100, '0, 15'h0100,
      {6'h00, 6'h10, 6'h03}, '1);
    chk(pc_new, 15'h0001);
    go(RELATIVE_BRANCH_OP, '0, '0, 9'h0FF, '0, 15'h7F80,
      {6'h00, 6'h10, 6'h03}, '1);
    chk(pc_new, 15'h0080);
    accum = 8'hFF;
    go(ACCUMULATOR_BRANCH_OP, '0, '0, '0, '0, 15'h0010,
      {6'h00, 6'h10, 6'h03}, '1);
    chk(pc_new, 15'h0110);
    $display("t_branch finished");
  endtask

  // Push before load; latch bits outside [6:3] must be ignored
  task automatic t_call();
    latch = 8'h78;
    go(SUBROUTINE_CALL_OP, '0, '0, '0, 11'h7FF, 15'h1234,
      {6'h00, 6'h08, 6'h13}, '1);
    chk(top_of_return_stack, 15'h1235);
    chk(pc_new, 15'h7FFF);
    latch = 8'h87;
    go(SUBROUTINE_CALL_OP, '0, '0, '0, 11'h000, 15'h7FFF,
      {6'h00, 6'h08, 6'h13}, '1);
    chk(top_of_return_stack, 15'h0000);
    chk(pc_new, 15'h0000);
    $display("t_call finished");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    cyc++;
    if (cyc == 1000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    for (int a = 0; a < 128; a++) i_mem.mem[a] = 8'h00;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    chk(in_ready, 1'b1);
    t_bits();
    t_skip();
    t_branch();
    t_call();
    conclude();
  end
endmodule
